// [rtl/sdrseq_ctrl.v]
/*
 * SDRAM controller side of power-up initialisation, self-refresh entry and
 * exit, and periodic auto-refresh requests.
 * Assumes the SDRAM clock is clk_sys_i gated by sdr_clk_en_o outside.
 */
// Operation
// - Hold clock-enable low, masks high, no-operation while supply ramps.
// - Run stable clock at least 200 us before raising clock-enable.
// - Keep byte masks high while clock-enable rises.
// - Precharge all banks during initialisation.
// - Issue mode register set during initialisation.
// - Issue at least two auto-refresh commands during initialisation.
// - Init auto-refreshes may precede or follow mode register set.
// - Enter self-refresh: select, row, column strobes low, clock-enable low.
// - Wait at least row active time after entry before exiting.
// - Restart clock and let it settle before raising clock-enable.
// - Begin self-refresh exit with chip select high.
// - Wait self-refresh exit time after clock-enable rises before commands.
// - Burst refresh mode: 4096 auto-refreshes before entry and after exit.
// - Exit time equals row cycle time plus input setup time.
// - Row active minimum 40 or 42 ns; same minimum for self-refresh dwell.
// - Wait two clocks after mode register set before next command.
// - Average auto-refresh interval no longer than 15.6 us.
`timescale 1ns/1ns
`include "sdrseq_map.vh"
module sdrseq_ctrl #(
	parameter PWRUP_CYC = `SDRSEQ_T_PWRUP_CYC,
	parameter BURST_CNT = `SDRSEQ_BURST_REFRESHES,
	parameter REFI_CYC = `SDRSEQ_T_REFI_CYC,
	parameter INIT_AREF = `SDRSEQ_INIT_REFRESHES,
	parameter AREF_FIRST = 0,
	parameter [11:0] MODE_WORD = `SDRSEQ_MODE_DEFAULT
) (
	input wire clk_sys_i, // System clock, 125 MHz.
	input wire sys_rst_i, // Asynchronous reset, active high.
	input wire burst_mode_i, // Use burst refresh around self-refresh.
	input wire sr_req_i, // Level: request self-refresh.
	input wire user_cmd_i, // Level: user wants a command slot.
	output wire init_done_o, // Initialisation finished.
	output wire in_sr_o, // Sequencer is in the self-refresh dwell state; low once the exit path starts.
	output wire idle_o, // Ready for user commands.
	output reg sdr_clk_en_o, // Gate for the SDRAM clock.
	output reg sdr_cke_o, // Clock enable pin.
	output reg sdr_cs_n_o, // Chip select, active low.
	output reg sdr_ras_n_o, // Row strobe, active low.
	output reg sdr_cas_n_o, // Column strobe, active low.
	output reg sdr_we_n_o, // Write enable, active low.
	output reg [3:0] sdr_dqm_o, // Byte masks.
	output reg [1:0] sdr_ba_o, // Bank address.
	output reg [11:0] sdr_addr_o // Address.
);
	localparam S_PWRUP = 12'h001;
	localparam S_PRE = 12'h002;
	localparam S_AREF = 12'h004;
	localparam S_MRS = 12'h008;
	localparam S_IDLE = 12'h010;
	localparam S_BPRE = 12'h020;
	localparam S_SRENT = 12'h040;
	localparam S_SRDWL = 12'h080;
	localparam S_SRHLD = 12'h100;
	localparam S_CKRUN = 12'h200;
	localparam S_XSR = 12'h400;
	localparam S_BPOST = 12'h800;
	localparam TW = 16;
	localparam CW = 13;

	reg [11:0] st_q;
	reg [11:0] st_d;
	reg [CW-1:0] aref_q;
	reg [CW-1:0] aref_d;
	reg mrs_done_q;
	reg mrs_done_d;
	reg init_q;
	reg init_d;
	reg [TW-1:0] refi_q;
	reg ref_due_q;
	reg ld;
	reg [TW-1:0] ld_cnt;
	reg [3:0] cmd;
	reg cke_d;
	reg clk_en_d;
	reg dqm_hi;
	reg [11:0] addr_d;
	wire t_done;
	wire [TW-1:0] pwrup_w;

	// The power-up count must fit the timer; 200 us at 125 MHz needs 15 bits.
	assign pwrup_w = PWRUP_CYC[TW-1:0];

	// One shared down-counter times every wait. A state loads it when it issues a command
	// or starts a timed wait, so its done flag means the interval has run out.
	sdrseq_timer #(
		.WIDTH(TW)
	) u_timer (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.load_i(ld),
		.count_i(ld_cnt),
		.done_o(t_done)
	);

	function [TW-1:0] cyc;
		input integer n;
		begin
			cyc = n[TW-1:0];
		end
	endfunction

	always @* begin
		st_d = st_q;
		aref_d = aref_q;
		mrs_done_d = mrs_done_q;
		init_d = init_q;
		ld = 1'b0;
		ld_cnt = {TW{1'b0}};
		cmd = `SDRSEQ_CMD_NOP;
		cke_d = 1'b1;
		clk_en_d = 1'b1;
		dqm_hi = 1'b0;
		addr_d = 12'h000;
		case (st_q)
		S_SRHLD: begin
			// Reset lands here so the long power-up wait is loaded only once.
			cke_d = 1'b0;
			dqm_hi = 1'b1;
			ld = 1'b1;
			ld_cnt = pwrup_w;
			st_d = S_PWRUP;
		end
		S_PWRUP: begin
			cke_d = 1'b0;
			dqm_hi = 1'b1;
			if (t_done) begin
				// Masks stay high as clock-enable rises so data pins stay off.
				cke_d = 1'b1;
				st_d = S_PRE;
			end
		end
		S_PRE: begin
			dqm_hi = 1'b1;
			if (t_done) begin
				cmd = `SDRSEQ_CMD_PRECH;
				addr_d[`SDRSEQ_A10_ALLBANKS] = 1'b1;
				ld = 1'b1;
				ld_cnt = cyc(`SDRSEQ_T_RP_CYC);
				aref_d = {CW{1'b0}};
				st_d = (AREF_FIRST != 0) ? S_AREF : S_MRS;
			end
		end
		S_AREF: begin
			dqm_hi = 1'b1;
			if (t_done) begin
				if (aref_q < INIT_AREF[CW-1:0]) begin
					cmd = `SDRSEQ_CMD_AREF;
					aref_d = aref_q + {{(CW-1){1'b0}}, 1'b1};
					ld = 1'b1;
					ld_cnt = cyc(`SDRSEQ_T_RC_CYC);
				end else if (!mrs_done_q) begin
					st_d = S_MRS;
				end else begin
					init_d = 1'b1;
					st_d = S_IDLE;
				end
			end
		end
		S_MRS: begin
			dqm_hi = 1'b1;
			if (t_done) begin
				cmd = `SDRSEQ_CMD_MRS;
				addr_d = MODE_WORD;
				mrs_done_d = 1'b1;
				ld = 1'b1;
				ld_cnt = cyc(`SDRSEQ_T_MRD_CYC);
				st_d = (aref_q < INIT_AREF[CW-1:0]) ? S_AREF : S_IDLE;
				init_d = (aref_q >= INIT_AREF[CW-1:0]);
			end
		end
		S_IDLE: begin
			// A due refresh goes ahead of a self-refresh request.
			if (t_done) begin
				if (ref_due_q) begin
					cmd = `SDRSEQ_CMD_AREF;
					ld = 1'b1;
					ld_cnt = cyc(`SDRSEQ_T_RC_CYC);
				end else if (sr_req_i) begin
					aref_d = {CW{1'b0}};
					st_d = burst_mode_i ? S_BPRE : S_SRENT;
				end
			end
		end
		S_BPRE, S_BPOST: begin
			if (t_done) begin
				if (aref_q < BURST_CNT[CW-1:0]) begin
					cmd = `SDRSEQ_CMD_AREF;
					aref_d = aref_q + {{(CW-1){1'b0}}, 1'b1};
					ld = 1'b1;
					ld_cnt = cyc(`SDRSEQ_T_RC_CYC);
				end else begin
					st_d = (st_q == S_BPRE) ? S_SRENT : S_IDLE;
				end
			end
		end
		S_SRENT: begin
			// Clock-enable falls with the refresh command; the pair is entry.
			if (t_done) begin
				cke_d = 1'b0;
				cmd = `SDRSEQ_CMD_AREF;
				ld = 1'b1;
				ld_cnt = cyc(`SDRSEQ_T_RAS_CYC);
				st_d = S_SRDWL;
			end
		end
		S_SRDWL: begin
			cke_d = 1'b0;
			// The memory clock stops here to save power; the exit path
			// restarts it and lets it settle before clock-enable rises.
			clk_en_d = 1'b0;
			if (t_done && !sr_req_i) begin
				ld = 1'b1;
				ld_cnt = cyc(`SDRSEQ_T_CKSTB_CYC);
				st_d = S_CKRUN;
			end
		end
		S_CKRUN: begin
			cke_d = 1'b0;
			// Deselect rather than no-operation, so exit starts with select high.
			cmd = `SDRSEQ_CMD_DESEL;
			if (t_done) begin
				cke_d = 1'b1;
				ld = 1'b1;
				ld_cnt = cyc(`SDRSEQ_T_XSR_CYC);
				st_d = S_XSR;
			end
		end
		S_XSR: begin
			cmd = `SDRSEQ_CMD_DESEL;
			if (t_done) begin
				aref_d = {CW{1'b0}};
				st_d = burst_mode_i ? S_BPOST : S_IDLE;
			end
		end
		default: begin
			st_d = S_PWRUP;
		end
		endcase
	end

	// Reset leaves the pins as during supply ramp: masks high, no-operation.
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q <= S_SRHLD;
			aref_q <= {CW{1'b0}};
			mrs_done_q <= 1'b0;
			init_q <= 1'b0;
			sdr_clk_en_o <= 1'b1;
			sdr_cke_o <= 1'b0;
			{sdr_cs_n_o, sdr_ras_n_o, sdr_cas_n_o, sdr_we_n_o} <= 4'h7;
			sdr_dqm_o <= 4'hF;
			sdr_ba_o <= 2'h0;
			sdr_addr_o <= 12'h000;
		end else begin
			st_q <= st_d;
			aref_q <= aref_d;
			mrs_done_q <= mrs_done_d;
			init_q <= init_d;
			sdr_clk_en_o <= clk_en_d;
			sdr_cke_o <= cke_d;
			{sdr_cs_n_o, sdr_ras_n_o, sdr_cas_n_o, sdr_we_n_o} <= cmd;
			sdr_dqm_o <= dqm_hi ? 4'hF : 4'h0;
			sdr_ba_o <= 2'h0;
			sdr_addr_o <= addr_d;
		end
	end

	// Periodic refresh counter. It is cleared outside idle, so the first
	// refresh after init or exit comes one full interval later. Requests
	// are raised a few cycles early to absorb a wait for a busy timer,
	// which keeps the average interval inside the limit.
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			refi_q <= {TW{1'b0}};
			ref_due_q <= 1'b0;
		end else if (!init_q || st_q != S_IDLE) begin
			refi_q <= {TW{1'b0}};
			ref_due_q <= 1'b0;
		end else if (ld) begin
			ref_due_q <= 1'b0;
		end else if (refi_q >= REFI_CYC[TW-1:0] - 16'h0008) begin
			ref_due_q <= 1'b1;
			refi_q <= {TW{1'b0}};
		end else begin
			refi_q <= refi_q + 16'h0001;
		end
	end

	assign init_done_o = init_q;
	assign in_sr_o = (st_q == S_SRDWL);
	assign idle_o = init_q && (st_q == S_IDLE) && t_done && !ref_due_q
		&& !sr_req_i && user_cmd_i;
endmodule // sdrseq_ctrl

// [rtl/sdrseq_map.vh]
/*
 * Timing counts, command encodings and mode word defaults for the SDRAM
 * initialisation and self-refresh sequencer.
 * Assumes a 125 MHz system clock (8 ns period) driving the SDRAM clock.
 */
`ifndef SDRSEQ_MAP_VH
`define SDRSEQ_MAP_VH

`define SDRSEQ_CLK_PERIOD_NS 8
// Power-up stable clock time, in microseconds.
`define SDRSEQ_T_PWRUP_US 200
`define SDRSEQ_T_PWRUP_CYC ((`SDRSEQ_T_PWRUP_US * 1000) / `SDRSEQ_CLK_PERIOD_NS)
// Row active time, slowest grade, in ns, rounded up to cycles.
`define SDRSEQ_T_RAS_NS 42
`define SDRSEQ_T_RAS_CYC \
	((`SDRSEQ_T_RAS_NS + `SDRSEQ_CLK_PERIOD_NS - 1) / `SDRSEQ_CLK_PERIOD_NS)
// Row cycle time, slowest grade, in ns.
`define SDRSEQ_T_RC_NS 63
`define SDRSEQ_T_RC_CYC \
	((`SDRSEQ_T_RC_NS + `SDRSEQ_CLK_PERIOD_NS - 1) / `SDRSEQ_CLK_PERIOD_NS)
// Precharge time, slowest grade, in ns.
`define SDRSEQ_T_RP_NS 21
`define SDRSEQ_T_RP_CYC \
	((`SDRSEQ_T_RP_NS + `SDRSEQ_CLK_PERIOD_NS - 1) / `SDRSEQ_CLK_PERIOD_NS)
// Self-refresh exit: row cycle time plus 1.5 ns input setup, in tenths of ns.
`define SDRSEQ_T_IS_NS10 15
`define SDRSEQ_T_XSR_CYC ((`SDRSEQ_T_RC_NS * 10 + `SDRSEQ_T_IS_NS10 + \
	`SDRSEQ_CLK_PERIOD_NS * 10 - 1) / (`SDRSEQ_CLK_PERIOD_NS * 10))
// Mode register set cycle time, in clocks.
`define SDRSEQ_T_MRD_CYC 2
// Refresh interval, 15.6 us in tenths of us, rounded down to cycles.
`define SDRSEQ_T_REFI_US10 156
`define SDRSEQ_T_REFI_CYC ((`SDRSEQ_T_REFI_US10 * 100) / `SDRSEQ_CLK_PERIOD_NS)
// Clock restart settle time before raising clock-enable, in clocks.
`define SDRSEQ_T_CKSTB_CYC 8
`define SDRSEQ_INIT_REFRESHES 2
`define SDRSEQ_BURST_REFRESHES 4096
`define SDRSEQ_MODE_DEFAULT 12'h032
// Command encodings {cs_n, ras_n, cas_n, we_n}.
`define SDRSEQ_CMD_DESEL 4'h8
`define SDRSEQ_CMD_NOP 4'h7
`define SDRSEQ_CMD_PRECH 4'h2
`define SDRSEQ_CMD_AREF 4'h1
`define SDRSEQ_CMD_MRS 4'h0
`define SDRSEQ_A10_ALLBANKS 10

`endif

// [rtl/sdrseq_timer.v]
/*
 * Down-counting wait timer for the sequencer.
 * Assumes the loader pulses load_i for one cycle with a nonzero count.
 */
`timescale 1ns/1ns
module sdrseq_timer #(
	parameter WIDTH = 16
) (
	input wire clk_sys_i, // System clock.
	input wire sys_rst_i, // Asynchronous reset, active high.
	input wire load_i, // Load a new count.
	input wire [WIDTH-1:0] count_i, // Cycles to wait.
	output wire done_o // Count has run out.
);
	reg [WIDTH-1:0] cnt_q;

	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_q <= {WIDTH{1'b0}};
		end else if (load_i) begin
			cnt_q <= count_i - {{(WIDTH-1){1'b0}}, 1'b1};
		end else if (cnt_q != {WIDTH{1'b0}}) begin
			cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// Done is a plain decode of the count. Gating it with the load would
	// close a loop, since every sequencer load but the one in S_SRHLD waits on done.
	assign done_o = (cnt_q == {WIDTH{1'b0}});
endmodule // sdrseq_timer

// [verif/sdrseq_asserts.sv]
/* Pin-level assertions for sdrseq_ctrl.
 * Assumes one clock domain; bound into every sdrseq_ctrl. */
`timescale 1ns/1ns
module sdrseq_asserts #(
	parameter PWRUP_CYC = 20
) (
	input wire clk_sys_i, // Clock.
	input wire sys_rst_i, // Reset.
	input wire init_done_o, // Init done.
	input wire sdr_clk_en_o, // Clock gate.
	input wire sdr_cke_o, // Clock enable.
	input wire sdr_cs_n_o, // Select.
	input wire sdr_ras_n_o, // Row strobe.
	input wire sdr_cas_n_o, // Column strobe.
	input wire sdr_we_n_o, // Write enable.
	input wire [3:0] sdr_dqm_o, // Masks.
	input wire [11:0] sdr_addr_o // Address.
);
	wire [3:0] cmd = {sdr_cs_n_o, sdr_ras_n_o, sdr_cas_n_o, sdr_we_n_o};
	wire quiet = sdr_cs_n_o || cmd == 4'h7;
	reg [15:0] up_q;
	// Counted from reset release, the latest point the clock is known good.
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			up_q <= 16'h0000;
		else if (up_q != 16'hFFFF)
			up_q <= up_q + 16'h0001;
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	property p_ramp;
		!sdr_cke_o && !init_done_o |-> sdr_dqm_o == 4'hF && quiet;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp pins");
	property p_pwrup;
		$rose(sdr_cke_o) && !init_done_o |-> up_q >= PWRUP_CYC && &sdr_dqm_o;
	endproperty
	a_pwrup: assert property (p_pwrup) else $error("cke early");
	property p_pre;
		cmd == 4'h2 |-> sdr_addr_o[10];
	endproperty
	a_pre: assert property (p_pre) else $error("not all banks");
	property p_mrd;
		cmd == 4'h0 |=> quiet;
	endproperty
	a_mrd: assert property (p_mrd) else $error("mode gap");
	property p_entry;
		$fell(sdr_cke_o) |-> cmd == 4'h1;
	endproperty
	a_entry: assert property (p_entry) else $error("bad entry");
	property p_dwell;
		$fell(sdr_cke_o) |=> !sdr_cke_o [*5];
	endproperty
	a_dwell: assert property (p_dwell) else $error("dwell");
	property p_exit;
		$rose(sdr_cke_o) && init_done_o |-> sdr_cs_n_o && $past(sdr_clk_en_o, 7);
	endproperty
	a_exit: assert property (p_exit) else $error("bad exit");
	property p_xsr;
		$rose(sdr_cke_o) && init_done_o |-> quiet [*8];
	endproperty
	a_xsr: assert property (p_xsr) else $error("exit gap");
	c_init: cover property ($rose(init_done_o));
	c_entry: cover property ($fell(sdr_cke_o));
	c_exit: cover property ($rose(sdr_cke_o) && init_done_o);
endmodule // sdrseq_asserts

bind sdrseq_ctrl sdrseq_asserts #(.PWRUP_CYC(PWRUP_CYC)) sdrseq_asserts_i (.*);

// [verif/sdrseq_ctrl_bench.sv]
/* Self-checking bench for sdrseq_ctrl against a device model.
 * Assumes rtl is on the include path. */
`timescale 1ns/1ns
module sdrseq_ctrl_bench;
	localparam PWRUP = 20;
	localparam BURST = 4;
	localparam REFI = 300;
	reg clk_sys_i = 1'h0;
	reg sys_rst_i = 1'h1;
	reg burst_mode_i = 1'h0;
	reg sr_req_i = 1'h0;
	reg user_cmd_i = 1'h0;
	reg gate_q = 1'h1;
	reg [1:0] bad;
	wire init_done_o, in_sr_o, idle_o, sdr_clk_en_o, sdr_cke_o;
	wire sdr_cs_n_o, sdr_ras_n_o, sdr_cas_n_o, sdr_we_n_o;
	wire [3:0] sdr_dqm_o;
	wire [1:0] sdr_ba_o;
	wire [11:0] sdr_addr_o;
	wire dev_sr;
	wire [15:0] dev_arefs, dev_mode, dev_pre;
	integer miscompares = 0;
	integer checks_done = 0;
	integer n0;
	integer p0;
	integer m0;
	integer i;
	always #4 clk_sys_i = !clk_sys_i;
	// Gate moves on the falling edge so the memory clock never glitches.
	always @(negedge clk_sys_i) gate_q <= sdr_clk_en_o;
	sdrseq_ctrl #(.PWRUP_CYC(PWRUP), .BURST_CNT(BURST), .REFI_CYC(REFI))
		sdrseq_ctrl_i (.*);
	sdrseq_dev_model sdrseq_dev_model_i (.clk_i(clk_sys_i & gate_q),
		.cke_i(sdr_cke_o), .cmd_i({sdr_cs_n_o, sdr_ras_n_o, sdr_cas_n_o,
		sdr_we_n_o}), .a10_i(sdr_addr_o[10]), .sr_o(dev_sr),
		.arefs_o(dev_arefs), .mode_o(dev_mode), .pre_o(dev_pre));
	task check(input [31:0] seen, input [31:0] exp, input [8*12:1] what);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("[ERR] %0s exp %0h seen %0h", what, exp, seen);
			end
		end
	endtask
	task final_report;
		begin
			$display("checks %0d mismatches %0d", checks_done, miscompares);
			if (miscompares == 0 && checks_done > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task t_init(input hold);
		begin
			n0 = dev_arefs;
			p0 = dev_pre;
			m0 = dev_mode;
			sys_rst_i = 1'h1;
			sr_req_i = hold;
			burst_mode_i = 1'h0;
			repeat (20) @(negedge clk_sys_i);
			check(sdr_cke_o, 1'h0, "cke_rst");
			check(sdr_dqm_o, 4'hF, "dqm_rst");
			sys_rst_i = 1'h0;
			bad = 2'h0;
			for (i = 0; i < 500 && init_done_o !== 1'h1; i = i + 1) begin
				@(negedge clk_sys_i);
				if (i < PWRUP && sdr_cke_o !== 1'h0)
					bad[0] = 1'h1;
				if (in_sr_o !== 1'h0)
					bad[1] = 1'h1;
			end
			check(init_done_o, 1'h1, "init_done");
			check(bad, 2'h0, "init_early");
			check(dev_pre - p0, 32'h1, "pre_all");
			check(dev_mode - m0, 32'h1, "mode_set");
			check(sdr_ba_o, 2'h0, "bank_addr");
			check(dev_arefs - n0, 2'h2, "init_aref");
			$display("test init ends");
		end
	endtask
	task t_sr(input b);
		begin
			burst_mode_i = b;
			n0 = dev_arefs;
			sr_req_i = 1'h1;
			for (i = 0; i < 300 && in_sr_o !== 1'h1; i = i + 1)
				@(negedge clk_sys_i);
			// The model takes the entry one edge after the state moves.
			@(negedge clk_sys_i);
			check(dev_sr, 1'h1, "dev_in_sr");
			check(dev_arefs - n0, b ? BURST : 0, "burst_pre");
			repeat (30) @(negedge clk_sys_i);
			check(dev_sr, 1'h1, "sr_stays");
			check(sdr_cke_o, 1'h0, "sr_dwell");
			check(sdr_clk_en_o, 1'h0, "clk_stop");
			n0 = dev_arefs;
			sr_req_i = 1'h0;
			user_cmd_i = 1'h1;
			for (i = 0; i < 300 && idle_o !== 1'h1; i = i + 1)
				@(negedge clk_sys_i);
			check(dev_sr, 1'h0, "sr_left");
			check(i >= 17, 1'h1, "exit_wait");
			check(i < 300, 1'h1, "exit_done");
			check(dev_arefs - n0, b ? BURST : 0, "burst_post");
			$display("test self refresh ends");
		end
	endtask
	task t_refi;
		begin
			n0 = dev_arefs;
			user_cmd_i = 1'h1;
			repeat (3 * REFI) @(negedge clk_sys_i);
			user_cmd_i = 1'h0;
			check(dev_arefs - n0 >= 3, 1'h1, "refi");
			$display("test refresh ends");
		end
	endtask
	initial begin
		t_init(1'h0);
		t_sr(1'h0);
		t_sr(1'h1);
		t_refi;
		t_init(1'h1);
		t_sr(1'h0);
		final_report;
	end
	// The whole run needs well under two thousand cycles; this is far beyond that.
	initial begin
		#(8 * 20000);
		miscompares = miscompares + 1;
		final_report;
	end
endmodule // sdrseq_ctrl_bench

// [verif/sdrseq_dev_model.sv]
/* Behavioural SDRAM device: self-refresh state and init bookkeeping.
 * Assumes clk_i is the memory clock, stopped while gated off. */
`timescale 1ns/1ns
module sdrseq_dev_model (
	input wire clk_i, // Memory clock.
	input wire cke_i, // Clock enable.
	input wire [3:0] cmd_i, // Select, row, column, write strobes.
	input wire a10_i, // All-bank flag.
	output reg sr_o = 1'h0, // In self-refresh.
	output reg [15:0] arefs_o = 16'h0000, // Auto-refreshes taken.
	output reg [15:0] mode_o = 16'h0000, // Mode register loads taken.
	output reg [15:0] pre_o = 16'h0000 // All-bank precharges taken.
);
	reg cke_q = 1'h0;
	always @(posedge clk_i) begin
		cke_q <= cke_i;
		// Only clock-enable is heard in self-refresh; the clock may stop.
		if (sr_o)
			sr_o <= !cke_i;
		else if (cke_q && !cke_i && cmd_i == 4'h1)
			sr_o <= 1'h1;
		else if (cke_q && cmd_i == 4'h1)
			arefs_o <= arefs_o + 16'h0001;
		else if (cke_q && cmd_i == 4'h0)
			mode_o <= mode_o + 16'h0001;
		else if (cke_q && cmd_i == 4'h2 && a10_i)
			pre_o <= pre_o + 16'h0001;
	end
endmodule // sdrseq_dev_model
